/* File: hw/t1ri_pkg.sv */
package t1ri_pkg;
  // Register indices on the parallel port
  localparam logic [7:0] T1RI_ADDR_FLAGS_A = 8'h22;
  localparam logic [7:0] T1RI_ADDR_FLAGS_B = 8'h31;
  localparam logic [7:0] T1RI_FLAGS_RESET = 8'h00;
  localparam logic [7:0] T1RI_RDATA_UNMAPPED = 8'h00;

  // Bit positions, receive_event_flags_a
  localparam int T1RI_A_ALIGN_CHANGE = 7;
  localparam int T1RI_A_EIGHT_ZERO = 6;
  localparam int T1RI_A_SIXTEEN_ZERO = 5;
  localparam int T1RI_A_RX_STORE_FULL = 4;
  localparam int T1RI_A_RX_STORE_EMPTY = 3;
  localparam int T1RI_A_SEVERE_FRAMING = 2;
  localparam int T1RI_A_CODE_WORD = 1;
  localparam int T1RI_A_FRAME_BIT_ERR = 0;

  // Bit positions, receive_event_flags_b
  localparam int T1RI_B_SYNC_ACHIEVED = 7;
  localparam int T1RI_B_CARRIER_RESTORED = 6;
  localparam int T1RI_B_TX_STORE_FULL = 5;
  localparam int T1RI_B_TX_STORE_EMPTY = 4;
  localparam int T1RI_B_TX_STORE_SLIP = 3;
  localparam int T1RI_B_BLUE_CLEAR = 2;
  localparam int T1RI_B_RX_DENSITY = 1;
  localparam int T1RI_B_TX_DENSITY = 0;

  // Zero-run thresholds and framing error window
  localparam int T1RI_ZERO_RUN_SHORT = 8;
  localparam int T1RI_ZERO_RUN_LONG = 16;
  localparam int T1RI_FBIT_WINDOW = 6;
  localparam int T1RI_FBIT_ERR_LIMIT = 2;
endpackage

/* File: hw/t1ri_flags.sv */
`timescale 1ns/1ps
// Function
// RULE_01 - Flag register A at offset 0x22, eight event flags, MSB first.
// RULE_02 - Flag register B at offset 0x31: clears, transmit store, density flags.
// RULE_03 - Eight-zero flag on a run of eight zeros, any line code.
// RULE_04 - Sixteen-zero flag on a run of sixteen zeros, any line code.
// RULE_05 - Sync-achieved flag on gaining sync, held until read.
// RULE_06 - Carrier-restored flag when carrier returns, held until read.
// RULE_07 - Transmit store full flag when a frame is dropped on overflow.
// RULE_08 - Transmit store empty flag when a frame is repeated on underflow.
// RULE_09 - Transmit slip flag on either repeat or drop.
// RULE_10 - Blue-alarm clear flag when all-ones alarm ends, held until read.
// RULE_11 - Receive density flag on receive ones-density violation.
// RULE_12 - Transmit density flag on transmit ones-density violation.
// RULE_13 - All flags latched until read; cleared by read unless event recurs.
// RULE_14 - Mask write refreshes ones bits from live flags, holds zero bits.
// RULE_15 - Host writes mask, reads, ANDs with mask, writes result back.
// RULE_16 - Severe framing flag on two of six bad framing bits; any error flags.
// RULE_17 - Code word flag on any substitution code word, decoding on or off.
module t1ri_flags
  import t1ri_pkg::*;
#(
  parameter int ZERO_CNT_W = 5
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  input wire logic i_rx_pos,
  input wire logic i_rx_neg,
  input wire logic i_rx_strobe,
  input wire logic i_align_change_ev,
  input wire logic i_rx_store_full_ev,
  input wire logic i_rx_store_empty_ev,
  input wire logic i_fbit_valid,
  input wire logic i_fbit_err,
  input wire logic i_code_word_ev,
  input wire logic i_sync_ok,
  input wire logic i_carrier_ok,
  input wire logic i_blue_alarm,
  input wire logic i_tx_store_full_ev,
  input wire logic i_tx_store_empty_ev,
  input wire logic i_rx_density_ev,
  input wire logic i_tx_density_ev
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic strobe_last_reg;
  logic bit_take;
  logic bit_zero;

  // Two stages for the receive pins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      strobe_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {i_rx_strobe, i_rx_neg, i_rx_pos};
      pin_sync_reg <= pin_meta_reg;
      strobe_last_reg <= pin_sync_reg[2];
    end
  end

  assign bit_take = pin_sync_reg[2] & ~strobe_last_reg;
  assign bit_zero = ~pin_sync_reg[1] & ~pin_sync_reg[0];

  // ==========================================================
  // Zero-run detection
  // ==========================================================
  logic [ZERO_CNT_W-1:0] zero_cnt_reg;
  logic zero8_ev;
  logic zero16_ev;

  // Saturating count of consecutive zero bits
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      zero_cnt_reg <= '0;
    end else if (bit_take) begin
      if (!bit_zero) begin
        zero_cnt_reg <= '0;
      end else if (zero_cnt_reg != ZERO_CNT_W'(T1RI_ZERO_RUN_LONG)) begin
        zero_cnt_reg <= zero_cnt_reg + ZERO_CNT_W'(1);
      end
    end
  end

  // Either rail marks a one, so line code does not matter
  assign zero8_ev = bit_take & bit_zero &
                    (zero_cnt_reg >= ZERO_CNT_W'(T1RI_ZERO_RUN_SHORT - 1)); // [RULE_03]
  assign zero16_ev = bit_take & bit_zero &
                     (zero_cnt_reg >= ZERO_CNT_W'(T1RI_ZERO_RUN_LONG - 1)); // [RULE_04]

  // ==========================================================
  // Framing bit window and level edges
  // ==========================================================
  logic [T1RI_FBIT_WINDOW-1:0] fbit_hist_reg;
  logic [T1RI_FBIT_WINDOW-1:0] fbit_hist_next;
  logic [2:0] fbit_err_cnt;
  logic sev_frame_ev;
  logic sync_last_reg;
  logic carrier_last_reg;
  logic blue_last_reg;

  // Six most recent framing bit outcomes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fbit_hist_reg <= '0;
    end else if (i_fbit_valid) begin
      fbit_hist_reg <= fbit_hist_next;
    end
  end

  assign fbit_hist_next = {fbit_hist_reg[T1RI_FBIT_WINDOW-2:0], i_fbit_err};

  // Errors in the window including the new bit
  always_comb begin
    fbit_err_cnt = 3'h0;
    for (int i = 0; i < T1RI_FBIT_WINDOW; i++) begin
      fbit_err_cnt = fbit_err_cnt + {2'h0, fbit_hist_next[i]};
    end
  end

  assign sev_frame_ev = i_fbit_valid & i_fbit_err &
                        (fbit_err_cnt >= 3'(T1RI_FBIT_ERR_LIMIT)); // [RULE_16]

  // Previous levels for clear-event edges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_last_reg <= 1'b1;
      carrier_last_reg <= 1'b1;
      blue_last_reg <= 1'b0;
    end else begin
      sync_last_reg <= i_sync_ok;
      carrier_last_reg <= i_carrier_ok;
      blue_last_reg <= i_blue_alarm;
    end
  end

  // ==========================================================
  // Event vectors
  // ==========================================================
  logic [7:0] ev_a;
  logic [7:0] ev_b;

  always_comb begin
    ev_a = 8'h00;
    ev_a[T1RI_A_ALIGN_CHANGE] = i_align_change_ev;
    ev_a[T1RI_A_EIGHT_ZERO] = zero8_ev; // [RULE_03]
    ev_a[T1RI_A_SIXTEEN_ZERO] = zero16_ev; // [RULE_04]
    ev_a[T1RI_A_RX_STORE_FULL] = i_rx_store_full_ev;
    ev_a[T1RI_A_RX_STORE_EMPTY] = i_rx_store_empty_ev;
    ev_a[T1RI_A_SEVERE_FRAMING] = sev_frame_ev; // [RULE_16]
    ev_a[T1RI_A_CODE_WORD] = i_code_word_ev; // [RULE_17]
    ev_a[T1RI_A_FRAME_BIT_ERR] = i_fbit_valid & i_fbit_err; // [RULE_16]
    ev_b = 8'h00;
    ev_b[T1RI_B_SYNC_ACHIEVED] = i_sync_ok & ~sync_last_reg; // [RULE_05]
    ev_b[T1RI_B_CARRIER_RESTORED] = i_carrier_ok & ~carrier_last_reg; // [RULE_06]
    ev_b[T1RI_B_TX_STORE_FULL] = i_tx_store_full_ev; // [RULE_07]
    ev_b[T1RI_B_TX_STORE_EMPTY] = i_tx_store_empty_ev; // [RULE_08]
    ev_b[T1RI_B_TX_STORE_SLIP] = i_tx_store_full_ev | i_tx_store_empty_ev; // [RULE_09]
    ev_b[T1RI_B_BLUE_CLEAR] = ~i_blue_alarm & blue_last_reg; // [RULE_10]
    ev_b[T1RI_B_RX_DENSITY] = i_rx_density_ev; // [RULE_11]
    ev_b[T1RI_B_TX_DENSITY] = i_tx_density_ev; // [RULE_12]
  end

  // ==========================================================
  // Live flags, held read values, port
  // ==========================================================
  logic sel_a;
  logic sel_b;
  logic [7:0] live_a_reg;
  logic [7:0] live_b_reg;
  logic [7:0] hold_a_reg;
  logic [7:0] hold_b_reg;

  assign sel_a = (i_addr == T1RI_ADDR_FLAGS_A); // [RULE_01]
  assign sel_b = (i_addr == T1RI_ADDR_FLAGS_B); // [RULE_02]

  // Sticky live flags; a mask write moves them out, new events win
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      live_a_reg <= T1RI_FLAGS_RESET;
      live_b_reg <= T1RI_FLAGS_RESET;
    end else begin
      live_a_reg <= (live_a_reg & ~((i_wr & sel_a) ? i_wdata : 8'h00)) | ev_a; // [RULE_13]
      live_b_reg <= (live_b_reg & ~((i_wr & sel_b) ? i_wdata : 8'h00)) | ev_b; // [RULE_13]
    end
  end

  // Ones in the mask refresh, zeros keep; a read empties the held copy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_a_reg <= T1RI_FLAGS_RESET;
      hold_b_reg <= T1RI_FLAGS_RESET;
    end else begin
      if (i_wr && sel_a) begin
        hold_a_reg <= (hold_a_reg & ~i_wdata) | (live_a_reg & i_wdata); // [RULE_14]
      end else if (i_rd && sel_a) begin
        hold_a_reg <= T1RI_FLAGS_RESET; // [RULE_13]
      end
      if (i_wr && sel_b) begin
        hold_b_reg <= (hold_b_reg & ~i_wdata) | (live_b_reg & i_wdata); // [RULE_14]
      end else if (i_rd && sel_b) begin
        hold_b_reg <= T1RI_FLAGS_RESET; // [RULE_13]
      end
    end
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= T1RI_RDATA_UNMAPPED;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd & ~i_wr;
      if (i_rd && !i_wr) begin
        o_rdata <= sel_a ? hold_a_reg : (sel_b ? hold_b_reg : T1RI_RDATA_UNMAPPED);
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_reg_a_read;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd && !i_wr && sel_a) |=> (o_rd_valid && o_rdata == $past(hold_a_reg));
  endproperty
  a_reg_a_read: assert property (p_reg_a_read) else $error("reg a read data wrong"); // [RULE_01]

  property p_reg_b_read;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd && !i_wr && sel_b) |=> (o_rd_valid && o_rdata == $past(hold_b_reg));
  endproperty
  a_reg_b_read: assert property (p_reg_b_read) else $error("reg b read data wrong"); // [RULE_02]

  property p_zero8;
    @(posedge i_clk) disable iff (i_rst)
      (bit_take && bit_zero && zero_cnt_reg == ZERO_CNT_W'(T1RI_ZERO_RUN_SHORT - 1))
      |=> live_a_reg[T1RI_A_EIGHT_ZERO];
  endproperty
  a_zero8: assert property (p_zero8) else $error("eighth zero not flagged"); // [RULE_03]

  property p_zero16;
    @(posedge i_clk) disable iff (i_rst)
      (bit_take && bit_zero && zero_cnt_reg == ZERO_CNT_W'(T1RI_ZERO_RUN_LONG - 1))
      |=> live_a_reg[T1RI_A_SIXTEEN_ZERO];
  endproperty
  a_zero16: assert property (p_zero16) else $error("sixteenth zero not flagged"); // [RULE_04]

  property p_sync_edge;
    @(posedge i_clk) disable iff (i_rst)
      (i_sync_ok && !$past(i_sync_ok)) |=> live_b_reg[T1RI_B_SYNC_ACHIEVED];
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("sync gain missed"); // [RULE_05]

  property p_slip;
    @(posedge i_clk) disable iff (i_rst)
      (i_tx_store_full_ev || i_tx_store_empty_ev) |=> live_b_reg[T1RI_B_TX_STORE_SLIP];
  endproperty
  a_slip: assert property (p_slip) else $error("slip not flagged"); // [RULE_09]

  property p_sticky;
    @(posedge i_clk) disable iff (i_rst)
      (live_b_reg[T1RI_B_BLUE_CLEAR] && !(i_wr && sel_b)) |=> live_b_reg[T1RI_B_BLUE_CLEAR];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write"); // [RULE_13]

  property p_mask_keep;
    @(posedge i_clk) disable iff (i_rst)
      (i_wr && sel_a) |=> ((hold_a_reg & ~$past(i_wdata)) == ($past(hold_a_reg) & ~$past(i_wdata)))
        && ((hold_a_reg & $past(i_wdata)) == ($past(live_a_reg) & $past(i_wdata)));
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("mask write wrong"); // [RULE_14]

  property p_sev_frame;
    @(posedge i_clk) disable iff (i_rst)
      sev_frame_ev |=> live_a_reg[T1RI_A_SEVERE_FRAMING] && live_a_reg[T1RI_A_FRAME_BIT_ERR];
  endproperty
  a_sev_frame: assert property (p_sev_frame) else $error("framing flags missed"); // [RULE_16]

  c_sixteen: cover property (@(posedge i_clk) disable iff (i_rst) zero16_ev);
  c_set_wins: cover property (@(posedge i_clk) disable iff (i_rst)
    i_wr && sel_b && i_wdata[T1RI_B_TX_STORE_SLIP] && ev_b[T1RI_B_TX_STORE_SLIP]);
  c_read_set: cover property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && sel_a) ##1 (i_rd && sel_a) ##1 (o_rdata != 8'h00));

endmodule // t1ri_flags

/* File: dv/t1ri_flags_tb.sv */
`timescale 1ns/1ps
// =============================================================
// Flag bank bench: mask-read-writeback through the port
module testbench;
  import t1ri_pkg::*;

  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  wire logic [7:0] o_rdata;
  wire logic o_rd_valid;
  logic i_rx_pos = 1'b0;
  logic i_rx_neg = 1'b0;
  logic i_rx_strobe = 1'b0;
  logic [7:0] ev = 8'h00;
  logic i_fbit_valid = 1'b0;
  logic i_fbit_err = 1'b0;
  logic i_sync_ok = 1'b1;
  logic i_carrier_ok = 1'b1;
  logic i_blue_alarm = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  logic [7:0] rv;
  // Per pulse event: register and expected flags
  localparam logic [7:0] EV_ADDR [8] = '{8'h22, 8'h22, 8'h22, 8'h22,
                                         8'h31, 8'h31, 8'h31, 8'h31};
  localparam logic [7:0] EV_EXP [8] = '{8'h80, 8'h10, 8'h08, 8'h02,
                                        8'h28, 8'h18, 8'h02, 8'h01};

  // Clock, 10 ns period
  always #5 i_clk = ~i_clk;

  t1ri_flags #(.ZERO_CNT_W(5)) i_t1ri_flags (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .i_rx_pos(i_rx_pos), .i_rx_neg(i_rx_neg), .i_rx_strobe(i_rx_strobe),
    .i_align_change_ev(ev[0]), .i_rx_store_full_ev(ev[1]),
    .i_rx_store_empty_ev(ev[2]), .i_fbit_valid(i_fbit_valid),
    .i_fbit_err(i_fbit_err), .i_code_word_ev(ev[3]), .i_sync_ok(i_sync_ok),
    .i_carrier_ok(i_carrier_ok), .i_blue_alarm(i_blue_alarm),
    .i_tx_store_full_ev(ev[4]), .i_tx_store_empty_ev(ev[5]),
    .i_rx_density_ev(ev[6]), .i_tx_density_ev(ev[7])
  );

  // =============================================================
  // Checking and closing
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // =============================================================
  // Port access tasks
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= addr;
    i_wdata <= data;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read, wait bounded for the valid pulse
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    int n;
    n = 0;
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= addr;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    while (o_rd_valid !== 1'b1 && n < 4) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk({7'h00, o_rd_valid}, 8'h01);
    data = o_rdata;
  endtask

  // Mask write, read and check, write back the masked result
  task automatic poll(input logic [7:0] addr, input logic [7:0] mask,
                      input logic [7:0] exp);
    wr(addr, mask);
    rd(addr, rv);
    chk(rv, exp);
    wr(addr, rv & mask);
  endtask

  // =============================================================
  // Stimulus helpers
  task automatic pulse(input int k);
    @(posedge i_clk);
    ev[k] <= 1'b1;
    @(posedge i_clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  // One receive bit; a one is sent on either rail
  task automatic rx_bit(input logic pos, input logic neg);
    @(posedge i_clk);
    i_rx_pos <= pos;
    i_rx_neg <= neg;
    repeat (2) @(posedge i_clk);
    i_rx_strobe <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_rx_strobe <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  task automatic fbit(input logic e);
    @(posedge i_clk);
    i_fbit_valid <= 1'b1;
    i_fbit_err <= e;
    @(posedge i_clk);
    i_fbit_valid <= 1'b0;
    i_fbit_err <= 1'b0;
  endtask

  // Watchdog against a hang
  initial begin
    #300us;
    err_count++;
    final_report();
  end

  // =============================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    poll(8'h22, 8'hff, T1RI_FLAGS_RESET);
    poll(8'h31, 8'hff, T1RI_FLAGS_RESET);
    wr(8'h40, 8'hff);
    rd(8'h40, rv);
    chk(rv, T1RI_RDATA_UNMAPPED);
    // Every pulse event, then cleared after the read
    for (int k = 0; k < 8; k++) begin
      pulse(k);
      poll(EV_ADDR[k], 8'hff, EV_EXP[k]);
      poll(EV_ADDR[k], 8'hff, 8'h00);
    end
    // Zero bits of the mask keep the held value
    pulse(3);
    wr(8'h22, 8'hff);
    pulse(0);
    wr(8'h22, 8'h80);
    rd(8'h22, rv);
    chk(rv, 8'h82);
    poll(8'h22, 8'h00, 8'h00);
    poll(8'h22, 8'hff, 8'h00);
    // Level transitions: sync and carrier rise, alarm falls
    @(posedge i_clk);
    i_sync_ok <= 1'b0;
    i_carrier_ok <= 1'b0;
    i_blue_alarm <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_sync_ok <= 1'b1;
    i_carrier_ok <= 1'b1;
    i_blue_alarm <= 1'b0;
    repeat (3) @(posedge i_clk);
    poll(8'h31, 8'hff, 8'hc4);
    poll(8'h31, 8'hff, 8'h00);
    // Zero runs: seven is not enough, eight and sixteen are
    rx_bit(1'b0, 1'b1);
    repeat (7) rx_bit(1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    poll(8'h22, 8'hff, 8'h00);
    rx_bit(1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    poll(8'h22, 8'hff, 8'h40);
    repeat (8) rx_bit(1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    poll(8'h22, 8'hff, 8'h60);
    rx_bit(1'b1, 1'b0);
    repeat (4) @(posedge i_clk);
    poll(8'h22, 8'hff, 8'h00);
    // Framing errors six apart, then two inside the window
    fbit(1'b1);
    repeat (5) fbit(1'b0);
    fbit(1'b1);
    repeat (2) @(posedge i_clk);
    poll(8'h22, 8'hff, 8'h01);
    repeat (4) fbit(1'b0);
    fbit(1'b1);
    repeat (2) @(posedge i_clk);
    poll(8'h22, 8'hff, 8'h05);
    final_report();
  end
endmodule // testbench
